/* pkg/pif2_pkg.sv */
// shared constants and types for the second peripheral flag block
package pif2_pkg;
	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FLAG_W = 8;
	localparam int CTRL_W = 3;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_ENABLES = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h10;

	// ------------------------------------------------------------
	// flag bit positions, shared by flags, enables, status, mask
	// ------------------------------------------------------------
	localparam int BIT_OSC_FAIL = 7;
	localparam int BIT_CMP_CHANGE = 6;
	localparam int BIT_BUS_COLL = 3;
	localparam int BIT_VOLT_DET = 2;
	localparam int BIT_TIMER3_COUNT_OVF = 1;
	localparam int BIT_CCP2 = 0;

	// control register fields
	localparam int CTRL_PERIPH_EN = 0;
	localparam int CTRL_PRIO_EN = 1;
	localparam int CTRL_GLOBAL_EN = 2;

	// ------------------------------------------------------------
	// masks and reset values
	// ------------------------------------------------------------
	localparam logic [FLAG_W-1:0] FLAG_IMPL_MASK = 8'hCF;
	localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
	localparam logic [DATA_W-FLAG_W-1:0] READ_PAD = 24'h000000;
	localparam logic [DATA_W-CTRL_W-1:0] CTRL_PAD = 29'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CCP_OFF = 2'b00,
		CCP_CAPTURE = 2'b01,
		CCP_COMPARE = 2'b10,
		CCP_PWM = 2'b11
	} pif2_ccp_mode_t;

	typedef enum logic {
		WR_COLLECT = 1'b0,
		WR_RESP = 1'b1
	} pif2_wr_state_t;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} pif2_rd_state_t;
endpackage : pif2_pkg

/* pkg/pif2_flag_if.sv */
// connection between the bus front end and the flag bank
`timescale 1ns/1ps
interface pif2_flag_if;
	logic [pif2_pkg::FLAG_W-1:0] set;
	logic wr_en;
	logic [pif2_pkg::FLAG_W-1:0] wr_data;
	logic [pif2_pkg::FLAG_W-1:0] flags;

	modport bank (
		input set,
		input wr_en,
		input wr_data,
		output flags
	);
	modport ctl (
		output set,
		output wr_en,
		output wr_data,
		input flags
	);
endinterface : pif2_flag_if

/* hdl/pif2_flag_bank.sv */
// per-bit sticky flag storage with software write access
`timescale 1ns/1ps
module pif2_flag_bank (
	input wire logic aclk,
	input wire logic aresetn,
	pif2_flag_if.bank fi
);
	// ------------------------------------------------------------
	// one sticky cell per implemented bit
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < pif2_pkg::FLAG_W; gi++) begin : g_bit
			logic bit_reg;
			logic bit_next;
			if (pif2_pkg::FLAG_IMPL_MASK[gi]) begin : g_impl
				// set beats a same-cycle software clear
				always_comb begin
					bit_next = fi.wr_en ? fi.wr_data[gi] : bit_reg;
					if (fi.set[gi]) begin
						bit_next = 1'b1;
					end
				end
			end else begin : g_unimpl
				// unused positions ignore writes, read zero
				always_comb begin
					bit_next = 1'b0;
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					bit_reg <= 1'b0;
				end else begin
					bit_reg <= bit_next;
				end
			end
			assign fi.flags[gi] = bit_reg;
		end
	endgenerate

	// ------------------------------------------------------------
	// assertions on the stored bits
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// nothing to set it and no write: a clear bit must stay clear
	sequence s_flag_quiet(int b);
		!fi.flags[b] && !fi.set[b] && !fi.wr_en;
	endsequence

	property p_osc_hold;
		fi.flags[pif2_pkg::BIT_OSC_FAIL] && !fi.wr_en
			|=> fi.flags[pif2_pkg::BIT_OSC_FAIL];
	endproperty
	a_osc_hold: assert property (p_osc_hold) else
		$error("osc fail flag dropped without software");

	property p_cmp_zero;
		s_flag_quiet(pif2_pkg::BIT_CMP_CHANGE)
			|=> !fi.flags[pif2_pkg::BIT_CMP_CHANGE];
	endproperty
	a_cmp_zero: assert property (p_cmp_zero) else
		$error("comparator flag rose without change");

	property p_timer3_count_zero;
		s_flag_quiet(pif2_pkg::BIT_TIMER3_COUNT_OVF)
			|=> !fi.flags[pif2_pkg::BIT_TIMER3_COUNT_OVF];
	endproperty
	a_timer3_count_zero: assert property (p_timer3_count_zero) else
		$error("timer3 flag rose without overflow");

	property p_unimpl;
		fi.flags[5:4] == 2'b00;
	endproperty
	a_unimpl: assert property (p_unimpl) else
		$error("unimplemented flag bits nonzero");
endmodule : pif2_flag_bank

/* hdl/pif2_top.sv */
// second peripheral interrupt flag register with AXI4-Lite access
//
// Function
// - Oscillator failure with switch-over sets a flag held until cleared.
// - A comparator change sets a flag held until software writes zero.
// - A voltage detector trip sets the flag held in bit 2.
// - Capture mode: a timer 1 capture sets the ccp2 flag until cleared.
// - Compare mode: a timer 1 match sets the ccp2 flag until cleared.
// - In pulse-width mode no event sets the capture/compare 2 flag.
// - Priority off: no request unless the peripheral global enable is set.
// - Flags set on their condition whatever the enables are.
`timescale 1ns/1ps
module pif2_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pif2_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pif2_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pif2_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pif2_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic osc_fail_event,
	input wire logic comparator_change_event,
	input wire logic bus_collision_event,
	input wire logic voltage_trip_event,
	input wire logic timer3_overflow_event,
	input wire logic ccp2_capture_event,
	input wire logic ccp2_compare_event,
	input wire logic [1:0] ccp2_mode,
	output logic peripheral_int_request,
	output logic irq
);
	pif2_flag_if fi ();
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	pif2_pkg::pif2_wr_state_t wr_state_reg, wr_state_next;
	pif2_pkg::pif2_rd_state_t rd_state_reg, rd_state_next;
	logic aw_have_reg, aw_have_next;
	logic w_have_reg, w_have_next;
	logic [pif2_pkg::ADDR_W-1:0] waddr_reg, waddr_next;
	logic [pif2_pkg::DATA_W-1:0] wdata_reg, wdata_next;
	logic wstrb0_reg, wstrb0_next;
	logic [1:0] bresp_reg, bresp_next;
	logic [pif2_pkg::DATA_W-1:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [pif2_pkg::FLAG_W-1:0] enables_reg, enables_next;
	logic [pif2_pkg::FLAG_W-1:0] status_reg, status_next;
	logic [pif2_pkg::FLAG_W-1:0] mask_reg, mask_next;
	logic [pif2_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic do_write;
	logic wr_hit;
	logic [pif2_pkg::FLAG_W-1:0] set_vec;
	logic any_pending;
	// ------------------------------------------------------------
	// condition capture
	// ------------------------------------------------------------
	// enables are not consulted here so that polling works
	always_comb begin
		set_vec = '0;
		set_vec[pif2_pkg::BIT_OSC_FAIL] = osc_fail_event;
		set_vec[pif2_pkg::BIT_CMP_CHANGE] = comparator_change_event;
		set_vec[pif2_pkg::BIT_BUS_COLL] = bus_collision_event;
		set_vec[pif2_pkg::BIT_VOLT_DET] = voltage_trip_event;
		set_vec[pif2_pkg::BIT_TIMER3_COUNT_OVF] = timer3_overflow_event;
		// pwm mode matches neither arm, so the flag stays idle
		set_vec[pif2_pkg::BIT_CCP2] =
			(ccp2_mode == pif2_pkg::CCP_CAPTURE && ccp2_capture_event) ||
			(ccp2_mode == pif2_pkg::CCP_COMPARE && ccp2_compare_event);
	end
	assign fi.set = set_vec;
	assign fi.wr_en = do_write && wstrb0_reg && waddr_reg == pif2_pkg::OFF_FLAGS;
	assign fi.wr_data = wdata_reg[pif2_pkg::FLAG_W-1:0];
	pif2_flag_bank u_bank (
		.aclk(aclk),
		.aresetn(aresetn),
		.fi(fi)
	);
	// ------------------------------------------------------------
	// request gating
	// ------------------------------------------------------------
	// priority scheme on bypasses the peripheral global enable
	assign any_pending = |(fi.flags & enables_reg);
	assign peripheral_int_request = any_pending &&
		ctrl_reg[pif2_pkg::CTRL_GLOBAL_EN] &&
		(ctrl_reg[pif2_pkg::CTRL_PRIO_EN] ||
		ctrl_reg[pif2_pkg::CTRL_PERIPH_EN]);
	assign irq = |(status_reg & mask_reg);
	// ------------------------------------------------------------
	// write channel handshakes
	// ------------------------------------------------------------
	assign s_axi_awready = wr_state_reg == pif2_pkg::WR_COLLECT && !aw_have_reg;
	assign s_axi_wready = wr_state_reg == pif2_pkg::WR_COLLECT && !w_have_reg;
	assign s_axi_bvalid = wr_state_reg == pif2_pkg::WR_RESP;
	assign s_axi_bresp = bresp_reg;
	assign do_write = wr_state_reg == pif2_pkg::WR_COLLECT &&
		aw_have_reg && w_have_reg;
	assign wr_hit = waddr_reg == pif2_pkg::OFF_FLAGS ||
		waddr_reg == pif2_pkg::OFF_ENABLES ||
		waddr_reg == pif2_pkg::OFF_CTRL ||
		waddr_reg == pif2_pkg::OFF_STATUS ||
		waddr_reg == pif2_pkg::OFF_MASK;
	// address and data may arrive in either order
	always_comb begin
		wr_state_next = wr_state_reg;
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb0_next = wstrb0_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_next = 1'b1;
			waddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb0_next = s_axi_wstrb[0];
		end
		case (wr_state_reg)
			pif2_pkg::WR_COLLECT: begin
				if (do_write) begin
					aw_have_next = 1'b0;
					w_have_next = 1'b0;
					bresp_next = wr_hit ? pif2_pkg::RESP_OKAY :
						pif2_pkg::RESP_SLVERR;
					wr_state_next = pif2_pkg::WR_RESP;
				end
			end
			pif2_pkg::WR_RESP: begin
				if (s_axi_bready) begin
					wr_state_next = pif2_pkg::WR_COLLECT;
				end
			end
			default: begin
				wr_state_next = pif2_pkg::WR_COLLECT;
			end
		endcase
	end
	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	// status is write-one-to-clear; a new event beats the clear
	always_comb begin
		enables_next = enables_reg;
		mask_next = mask_reg;
		ctrl_next = ctrl_reg;
		status_next = status_reg;
		if (do_write && wstrb0_reg) begin
			case (waddr_reg)
				pif2_pkg::OFF_ENABLES: begin
					enables_next = wdata_reg[pif2_pkg::FLAG_W-1:0] &
						pif2_pkg::FLAG_IMPL_MASK;
				end
				pif2_pkg::OFF_MASK: begin
					mask_next = wdata_reg[pif2_pkg::FLAG_W-1:0] &
						pif2_pkg::FLAG_IMPL_MASK;
				end
				pif2_pkg::OFF_CTRL: begin
					ctrl_next = wdata_reg[pif2_pkg::CTRL_W-1:0];
				end
				pif2_pkg::OFF_STATUS: begin
					status_next = status_reg &
						~wdata_reg[pif2_pkg::FLAG_W-1:0];
				end
				default: ctrl_next = ctrl_reg;
			endcase
		end
		status_next = status_next | set_vec;
	end
	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	assign s_axi_arready = rd_state_reg == pif2_pkg::RD_IDLE;
	assign s_axi_rvalid = rd_state_reg == pif2_pkg::RD_DATA;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	// unmapped reads answer zero with a slave error
	always_comb begin
		rd_state_next = rd_state_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		case (rd_state_reg)
			pif2_pkg::RD_IDLE: begin
				if (s_axi_arvalid) begin
					rd_state_next = pif2_pkg::RD_DATA;
					rresp_next = pif2_pkg::RESP_OKAY;
					case (s_axi_araddr)
						pif2_pkg::OFF_FLAGS: begin
							rdata_next = {pif2_pkg::READ_PAD, fi.flags};
						end
						pif2_pkg::OFF_ENABLES: begin
							rdata_next = {pif2_pkg::READ_PAD, enables_reg};
						end
						pif2_pkg::OFF_CTRL: begin
							rdata_next = {pif2_pkg::CTRL_PAD, ctrl_reg};
						end
						pif2_pkg::OFF_STATUS: begin
							rdata_next = {pif2_pkg::READ_PAD, status_reg};
						end
						pif2_pkg::OFF_MASK: begin
							rdata_next = {pif2_pkg::READ_PAD, mask_reg};
						end
						default: begin
							rdata_next = '0;
							rresp_next = pif2_pkg::RESP_SLVERR;
						end
					endcase
				end
			end
			pif2_pkg::RD_DATA: begin
				if (s_axi_rready) begin
					rd_state_next = pif2_pkg::RD_IDLE;
				end
			end
			default: begin
				rd_state_next = pif2_pkg::RD_IDLE;
			end
		endcase
	end
	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= pif2_pkg::WR_COLLECT;
			rd_state_reg <= pif2_pkg::RD_IDLE;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= '0;
			wstrb0_reg <= 1'b0;
			bresp_reg <= pif2_pkg::RESP_OKAY;
			rdata_reg <= '0;
			rresp_reg <= pif2_pkg::RESP_OKAY;
			enables_reg <= pif2_pkg::FLAG_RESET;
			status_reg <= pif2_pkg::FLAG_RESET;
			mask_reg <= pif2_pkg::FLAG_RESET;
			ctrl_reg <= pif2_pkg::CTRL_RESET;
		end else begin
			wr_state_reg <= wr_state_next;
			rd_state_reg <= rd_state_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			bresp_reg <= bresp_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			enables_reg <= enables_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			ctrl_reg <= ctrl_next;
		end
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_osc_set;
		osc_fail_event |=> fi.flags[pif2_pkg::BIT_OSC_FAIL];
	endproperty
	a_osc_set: assert property (p_osc_set) else
		$error("osc fail flag not set");
	property p_cmp_set;
		comparator_change_event |=> fi.flags[pif2_pkg::BIT_CMP_CHANGE];
	endproperty
	a_cmp_set: assert property (p_cmp_set) else
		$error("comparator flag not set");
	property p_bcl_set;
		bus_collision_event ##1 !fi.wr_en |=>
			fi.flags[pif2_pkg::BIT_BUS_COLL];
	endproperty
	a_bcl_set: assert property (p_bcl_set) else
		$error("bus collision flag not held");
	property p_volt_set;
		voltage_trip_event |=> fi.flags[2];
	endproperty
	a_volt_set: assert property (p_volt_set) else
		$error("voltage flag not in bit 2");
	property p_capture;
		ccp2_mode == pif2_pkg::CCP_CAPTURE && ccp2_capture_event
			|=> fi.flags[pif2_pkg::BIT_CCP2];
	endproperty
	a_capture: assert property (p_capture) else
		$error("capture did not set ccp2 flag");
	property p_compare;
		ccp2_mode == pif2_pkg::CCP_COMPARE && ccp2_compare_event
			|=> fi.flags[pif2_pkg::BIT_CCP2];
	endproperty
	a_compare: assert property (p_compare) else
		$error("compare did not set ccp2 flag");
	property p_pwm_idle;
		ccp2_mode == pif2_pkg::CCP_PWM && !fi.flags[pif2_pkg::BIT_CCP2] &&
			!fi.wr_en |=> !fi.flags[pif2_pkg::BIT_CCP2];
	endproperty
	a_pwm_idle: assert property (p_pwm_idle) else
		$error("ccp2 flag set in pwm mode");
	property p_periph_gate;
		!ctrl_reg[pif2_pkg::CTRL_PRIO_EN] &&
			!ctrl_reg[pif2_pkg::CTRL_PERIPH_EN] |-> !peripheral_int_request;
	endproperty
	a_periph_gate: assert property (p_periph_gate) else
		$error("request passed with peripheral enable off");
	property p_poll;
		enables_reg == '0 && timer3_overflow_event
			|=> fi.flags[pif2_pkg::BIT_TIMER3_COUNT_OVF];
	endproperty
	a_poll: assert property (p_poll) else
		$error("flag not set while disabled");
	property p_request;
		|(fi.flags & enables_reg) && ctrl_reg[pif2_pkg::CTRL_GLOBAL_EN] &&
			ctrl_reg[pif2_pkg::CTRL_PERIPH_EN] |-> peripheral_int_request;
	endproperty
	a_request: assert property (p_request) else
		$error("pending request not raised");
endmodule : pif2_top

/* test/pif2_periph_model.sv */
// peripheral model raising one-cycle condition pulses
`timescale 1ns/1ps
module pif2_periph_model (
	input wire logic aclk,
	input wire logic [7:0] fire,
	input wire logic [1:0] ccp2_mode,
	output logic osc_fail_event,
	output logic comparator_change_event,
	output logic bus_collision_event,
	output logic voltage_trip_event,
	output logic timer3_overflow_event,
	output logic ccp2_capture_event,
	output logic ccp2_compare_event
);
	// ------------------------------------------------------------
	// event pulses, launched the edge after a request
	// ------------------------------------------------------------
	// off and pwm modes still pulse both strobes, so the flag logic
	// itself has to ignore them there
	always_ff @(posedge aclk) begin
		osc_fail_event <= fire[pif2_pkg::BIT_OSC_FAIL];
		comparator_change_event <= fire[pif2_pkg::BIT_CMP_CHANGE];
		bus_collision_event <= fire[pif2_pkg::BIT_BUS_COLL];
		voltage_trip_event <= fire[pif2_pkg::BIT_VOLT_DET];
		timer3_overflow_event <= fire[pif2_pkg::BIT_TIMER3_COUNT_OVF];
		ccp2_capture_event <= fire[0] && ccp2_mode != pif2_pkg::CCP_COMPARE;
		ccp2_compare_event <= fire[0] && ccp2_mode != pif2_pkg::CCP_CAPTURE;
	end
endmodule : pif2_periph_model

/* test/pif2_top_tb.sv */
// self-checking bench for the second peripheral flag block
`timescale 1ns/1ps
module pif2_top_tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic aclk, aresetn;
	logic [7:0] awaddr, araddr, fire;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, mode, md;
	logic e_osc, e_cmp, e_bcl, e_vlt, e_tm3, e_cap, e_cmt;
	logic req, irq;
	logic [7:0] f, e, mk, m, w, st, ev;
	logic [2:0] c;
	int fails, tests_run;
	int bits[5] = '{7, 6, 3, 2, 1};

	pif2_top i_pif2_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.osc_fail_event(e_osc), .comparator_change_event(e_cmp),
		.bus_collision_event(e_bcl), .voltage_trip_event(e_vlt),
		.timer3_overflow_event(e_tm3), .ccp2_capture_event(e_cap),
		.ccp2_compare_event(e_cmt), .ccp2_mode(mode),
		.peripheral_int_request(req), .irq(irq));

	pif2_periph_model i_pif2_periph_model (.aclk(aclk), .fire(fire),
		.ccp2_mode(mode), .osc_fail_event(e_osc),
		.comparator_change_event(e_cmp), .bus_collision_event(e_bcl),
		.voltage_trip_event(e_vlt), .timer3_overflow_event(e_tm3),
		.ccp2_capture_event(e_cap), .ccp2_compare_event(e_cmt));

	// ------------------------------------------------------------
	// bench tasks and expectations
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// bready stays high, so the bvalid edge is the response handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// no private limit: a hung answer is left to the watchdog
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk(32'(bresp), 32'(er));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		chk(rdata, ed);
		chk(32'(rresp), 32'(er));
	endtask : rd

	// flag is visible two edges after the request
	task automatic pulse(input logic [7:0] p);
		fire <= p;
		@(posedge aclk);
		fire <= 8'h00;
		repeat (3) @(posedge aclk);
	endtask : pulse

	function automatic logic [7:0] ev_of(input logic [7:0] p,
		input logic [1:0] cm);
		ev_of = p & pif2_pkg::FLAG_IMPL_MASK;
		if (cm != pif2_pkg::CCP_CAPTURE && cm != pif2_pkg::CCP_COMPARE)
			ev_of[pif2_pkg::BIT_CCP2] = 1'b0;
	endfunction : ev_of

	function automatic logic exp_req(input logic [7:0] fl, en,
		input logic [2:0] ct);
		exp_req = |(fl & en) && ct[pif2_pkg::CTRL_GLOBAL_EN] &&
			(ct[pif2_pkg::CTRL_PRIO_EN] || ct[pif2_pkg::CTRL_PERIPH_EN]);
	endfunction : exp_req

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	// ------------------------------------------------------------
	// clock, watchdog, main sequence
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// whole run is under two thousand cycles
	initial begin
		repeat (30000) @(posedge aclk);
		fails++;
		summarize();
	end

	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, fire, wdata, mode} = '0;
		{awvalid, wvalid, arvalid} = '0;
		bready = 1'b1;
		rready = 1'b1;
		wstrb = 4'hF;
		fails = 0;
		tests_run = 0;
		st = 8'h00;
		void'($urandom(89));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// reset values, unmapped place
		for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, 2'h0);
		rd(8'h14, 32'h0, pif2_pkg::RESP_SLVERR);
		wr(8'h14, 32'hFF, pif2_pkg::RESP_SLVERR);
		// byte 0 strobe low: the write is answered but ignored
		wstrb <= 4'hE;
		wr(pif2_pkg::OFF_ENABLES, 32'hFF, pif2_pkg::RESP_OKAY);
		wstrb <= 4'hF;
		rd(pif2_pkg::OFF_ENABLES, 32'h0, pif2_pkg::RESP_OKAY);
		chk(32'(req), 32'h0);
		$display("test reset and map done");
		// each source but ccp2 with every enable off
		foreach (bits[i]) begin
			pulse(8'h01 << bits[i]);
			rd(pif2_pkg::OFF_FLAGS, 32'h1 << bits[i], 2'h0);
			rd(pif2_pkg::OFF_STATUS, 32'h1 << bits[i], 2'h0);
			chk(32'(req), 32'h0);
			wr(pif2_pkg::OFF_FLAGS, 32'h0, 2'h0);
			wr(pif2_pkg::OFF_STATUS, 32'hFF, 2'h0);
			rd(pif2_pkg::OFF_FLAGS, 32'h0, 2'h0);
		end
		$display("test sources done");
		// capture/compare source in every mode
		for (int k = 0; k < 4; k++) begin
			mode <= 2'(k);
			pulse(8'h01);
			rd(pif2_pkg::OFF_FLAGS, 32'(k == 1 || k == 2), 2'h0);
			wr(pif2_pkg::OFF_FLAGS, 32'h0, 2'h0);
			wr(pif2_pkg::OFF_STATUS, 32'hFF, 2'h0);
		end
		$display("test ccp modes done");
		// unimplemented bits
		wr(pif2_pkg::OFF_FLAGS, 32'hFFFFFFFF, 2'h0);
		rd(pif2_pkg::OFF_FLAGS, 32'hCF, 2'h0);
		wr(pif2_pkg::OFF_FLAGS, 32'h30, 2'h0);
		rd(pif2_pkg::OFF_FLAGS, 32'h0, 2'h0);
		// every gating code with all flags and enables set
		wr(pif2_pkg::OFF_FLAGS, 32'hFF, 2'h0);
		wr(pif2_pkg::OFF_ENABLES, 32'hFF, 2'h0);
		for (int k = 0; k < 8; k++) begin
			wr(pif2_pkg::OFF_CTRL, 32'(k), 2'h0);
			chk(32'(req), 32'(exp_req(8'hCF, 8'hCF, 3'(k))));
		end
		$display("test gating done");
		// random traffic: flags, enables, gating, status and mask
		for (int k = 0; k < 40; k++) begin
			f = 8'($urandom);
			e = 8'($urandom);
			c = 3'($urandom);
			mk = 8'($urandom);
			m = 8'($urandom);
			w = 8'($urandom);
			md = 2'($urandom);
			wr(pif2_pkg::OFF_FLAGS, 32'h0, 2'h0);
			wr(pif2_pkg::OFF_ENABLES, 32'(e), 2'h0);
			wr(pif2_pkg::OFF_CTRL, 32'(c), 2'h0);
			wr(pif2_pkg::OFF_MASK, 32'(mk), 2'h0);
			wr(pif2_pkg::OFF_FLAGS, 32'(f), 2'h0);
			mode <= md;
			pulse(m);
			ev = ev_of(m, md);
			f = (f & pif2_pkg::FLAG_IMPL_MASK) | ev;
			e = e & pif2_pkg::FLAG_IMPL_MASK;
			st = st | ev;
			rd(pif2_pkg::OFF_FLAGS, 32'(f), 2'h0);
			rd(pif2_pkg::OFF_ENABLES, 32'(e), 2'h0);
			rd(pif2_pkg::OFF_CTRL, 32'(c), 2'h0);
			rd(pif2_pkg::OFF_STATUS, 32'(st), 2'h0);
			chk(32'(req), 32'(exp_req(f, e, c)));
			chk(32'(irq), 32'(|(st & mk)));
			wr(pif2_pkg::OFF_STATUS, 32'(w), 2'h0);
			st = st & ~w;
			@(posedge aclk);
			chk(32'(irq), 32'(|(st & mk)));
			rd(pif2_pkg::OFF_MASK, 32'(mk & pif2_pkg::FLAG_IMPL_MASK), 2'h0);
		end
		$display("test random traffic done");
		summarize();
	end
endmodule : pif2_top_tb
